// ==== ppfc_pkg.sv ====
// Purpose: constants for the port pin function control block
// Assumes: byte-wide register port at fixed offsets
// Notes:   every offset, field position, reset value and count lives here
//
// How it works
// - strobe separates address from data in time
// - address output chosen pin by pin
// - select bit one drives address, zero I/O
// - high byte port B only, low both
// - port B byte chosen by configuration input
// - select and drive registers reset to zero
// - port A repeats data byte within window
// - window is OR of two selects
// - repeater active after enable bit seven set
// - repeater takes all eight port A pins
// - four test pins on port C reserved
// - drive types writable anytime, default push-pull
// - open-drain bit one means open drain
// - slew bit one means high slew
// - A/B bits 7-4 drain, 3-0 slew
// - port C bits 7,4,3,2 drain only
// - enable-out reads final pin enables anytime
// - enable combines array, direction, repeater
// - enable is array OR direction when address select, repeater and open drain are off; direction resets zero
package ppfc_pkg;
   localparam int          DATA_WIDTH       = 8;
   localparam int          ADDR_WIDTH       = 16;
   localparam int          REG_ADDR_WIDTH   = 8;
   // register offsets
   localparam logic [7:0]  OFS_A_ADDR_SEL   = 8'h02;
   localparam logic [7:0]  OFS_B_ADDR_SEL   = 8'h03;
   localparam logic [7:0]  OFS_A_DIR        = 8'h06;
   localparam logic [7:0]  OFS_B_DIR        = 8'h07;
   localparam logic [7:0]  OFS_A_DRIVE      = 8'h08;
   localparam logic [7:0]  OFS_B_DRIVE      = 8'h09;
   localparam logic [7:0]  OFS_A_OE_STATUS  = 8'h0C;
   localparam logic [7:0]  OFS_B_OE_STATUS  = 8'h0D;
   localparam logic [7:0]  OFS_C_DIR        = 8'h14;
   localparam logic [7:0]  OFS_C_DRIVE      = 8'h16;
   localparam logic [7:0]  OFS_C_OE_STATUS  = 8'h1A;
   localparam logic [7:0]  OFS_MAP_CTRL     = 8'hE0;
   // reset values
   localparam logic [7:0]  RESET_VALUE      = 8'h00;
   // field positions
   localparam int          REPEATER_EN_BIT  = 7;
   localparam logic [7:0]  DRAIN_FIELD_AB   = 8'hF0;
   localparam logic [7:0]  SLEW_FIELD_AB    = 8'h0F;
   localparam logic [7:0]  C_USABLE_MASK    = 8'h9C;
   localparam int          HIGH_BYTE_SHIFT  = 8;
endpackage

// ==== ppfc_addr_latch.sv ====
// Purpose: low address byte latch on strobe falling edge
// Assumes: strobe synchronous to clock from the CPU core
// Notes:   high byte passes straight through from the bus
`timescale 1ns/1ns
`default_nettype none
module ppfc_addr_latch #(
   parameter int ADDR_WIDTH = ppfc_pkg::ADDR_WIDTH
) (
   input  wire logic                  clock,
   input  wire logic                  reset_n,
   input  wire logic                  latch_strobe,
   input  wire logic [ADDR_WIDTH-1:0] bus_addr,
   output var  logic [ADDR_WIDTH-1:0] latched_addr
);
   typedef struct packed {
      logic       strobe_d;
      logic [7:0] low;
   } ppfc_latch_state_type;

   ppfc_latch_state_type state_reg;
   ppfc_latch_state_type state_next;

   // capture low byte when strobe falls
   always_comb begin
      state_next          = state_reg;
      state_next.strobe_d = latch_strobe;
      if (state_reg.strobe_d && !latch_strobe) begin
         state_next.low = bus_addr[7:0];
      end
   end

   always_ff @(posedge clock or negedge reset_n) begin
      if (!reset_n) begin
         state_reg <= '0;
      end else begin
         state_reg <= state_next;
      end
   end

   // high byte follows bus, low byte held between strobes
   assign latched_addr = {bus_addr[ADDR_WIDTH-1:8], state_reg.low};
endmodule
`default_nettype wire

// ==== ppfc_pin_slice.sv ====
// Purpose: one port pin output mux and enable combine
// Assumes: all inputs on the block clock
// Notes:   combinational; the top registers the results
`timescale 1ns/1ns
`default_nettype none
module ppfc_pin_slice (
   input  wire logic io_data,
   input  wire logic array_data,
   input  wire logic array_oe,
   input  wire logic array_owns,
   input  wire logic dir_bit,
   input  wire logic addr_sel,
   input  wire logic addr_bit,
   input  wire logic rep_active,
   input  wire logic rep_out,
   input  wire logic rep_data,
   input  wire logic open_drain,
   output var  logic pin_data,
   output var  logic pin_oe
);
   logic raw_data;
   logic raw_oe;

   // pick the pin function and its enable
   always_comb begin
      raw_data = io_data;
      raw_oe   = array_oe | dir_bit;
      if (rep_active) begin
         raw_data = rep_data;
         raw_oe   = rep_out;
      end else if (addr_sel) begin
         raw_data = addr_bit;
         raw_oe   = 1'b1;
      end else if (array_owns) begin
         raw_data = array_data;
      end
      // open drain drives only lows
      pin_data = open_drain ? 1'b0 : raw_data;
      pin_oe   = open_drain ? (raw_oe & ~raw_data) : raw_oe;
   end
endmodule
`default_nettype wire

// ==== ppfc_top.sv ====
// Purpose: port A/B/C special pin functions and drive control
// Assumes: CPU register port byte wide, synchronous to clock
// Notes:   all outputs registered; pin enables lag one cycle
`timescale 1ns/1ns
`default_nettype none
module ppfc_top #(
   parameter int W = ppfc_pkg::DATA_WIDTH
) (
   input  wire logic                                    clock,
   input  wire logic                                    reset_n,
   // register port
   input  wire logic [ppfc_pkg::REG_ADDR_WIDTH-1:0]     reg_addr,
   input  wire logic                                    reg_write,
   input  wire logic                                    reg_read,
   input  wire logic [W-1:0]                            reg_wdata,
   output var  logic [W-1:0]                            reg_rdata,
   // cpu bus
   input  wire logic                                    address_latch_strobe,
   input  wire logic [ppfc_pkg::ADDR_WIDTH-1:0]         cpu_addr,
   input  wire logic [W-1:0]                            cpu_wdata,
   input  wire logic                                    cpu_rd,
   input  wire logic                                    cpu_wr,
   output var  logic [W-1:0]                            cpu_rdata,
   output var  logic                                    cpu_rdata_valid,
   // decode array
   input  wire logic                                    peripheral_window_select_zero,
   input  wire logic                                    peripheral_window_select_one,
   input  wire logic [W-1:0]                            port_b_high_byte_cfg,
   input  wire logic [W-1:0]                            array_oe_a,
   input  wire logic [W-1:0]                            array_oe_b,
   input  wire logic [W-1:0]                            array_oe_c,
   input  wire logic [W-1:0]                            array_owns_a,
   input  wire logic [W-1:0]                            array_owns_b,
   input  wire logic [W-1:0]                            array_owns_c,
   input  wire logic [W-1:0]                            array_data_a,
   input  wire logic [W-1:0]                            array_data_b,
   input  wire logic [W-1:0]                            array_data_c,
   input  wire logic [W-1:0]                            io_data_a,
   input  wire logic [W-1:0]                            io_data_b,
   input  wire logic [W-1:0]                            io_data_c,
   // pins
   input  wire logic [W-1:0]                            port_a_in,
   output var  logic [W-1:0]                            port_a_out,
   output var  logic [W-1:0]                            port_a_oe,
   output var  logic [W-1:0]                            port_b_out,
   output var  logic [W-1:0]                            port_b_oe,
   output var  logic [W-1:0]                            port_c_out,
   output var  logic [W-1:0]                            port_c_oe,
   output var  logic [W-1:0]                            port_slew_fast
);
   typedef struct packed {
      logic [W-1:0] a_sel;
      logic [W-1:0] b_sel;
      logic [W-1:0] a_dir;
      logic [W-1:0] b_dir;
      logic [W-1:0] c_dir;
      logic [W-1:0] a_drv;
      logic [W-1:0] b_drv;
      logic [W-1:0] c_drv;
      logic [W-1:0] map_ctrl;
      logic [W-1:0] rdata;
      logic [W-1:0] a_out;
      logic [W-1:0] a_oe;
      logic [W-1:0] b_out;
      logic [W-1:0] b_oe;
      logic [W-1:0] c_out;
      logic [W-1:0] c_oe;
      logic [W-1:0] slew;
      logic [W-1:0] cpu_rdata;
      logic         cpu_valid;
      logic [W-1:0] pin_s1;
      logic [W-1:0] pin_s2;
      logic [W-1:0] pin_s3;
   } ppfc_state_type;

   ppfc_state_type state_reg;
   ppfc_state_type state_next;

   logic [ppfc_pkg::ADDR_WIDTH-1:0] latched_addr;
   logic [W-1:0]                    a_pin_d;
   logic [W-1:0]                    a_pin_e;
   logic [W-1:0]                    b_pin_d;
   logic [W-1:0]                    b_pin_e;
   logic [W-1:0]                    c_pin_d;
   logic [W-1:0]                    c_pin_e;
   logic [W-1:0]                    b_addr;
   logic                            window;
   logic                            rep_active;
   logic                            rep_out;

   // *******************************************
   // address latch
   // *******************************************
   ppfc_addr_latch #(.ADDR_WIDTH(ppfc_pkg::ADDR_WIDTH)) u_latch (
      .clock        (clock),
      .reset_n      (reset_n),
      .latch_strobe (address_latch_strobe),
      .bus_addr     (cpu_addr),
      .latched_addr (latched_addr)
   );

   // *******************************************
   // repeater window
   // *******************************************
   assign window     = peripheral_window_select_zero | peripheral_window_select_one;
   assign rep_active = state_reg.map_ctrl[ppfc_pkg::REPEATER_EN_BIT];
   assign rep_out    = rep_active & window & cpu_wr;

   // *******************************************
   // per pin slices
   // *******************************************
   genvar gi;
   generate
      for (gi = 0; gi < W; gi++) begin : g_pin
         // port B byte picked by configuration
         assign b_addr[gi] = port_b_high_byte_cfg[gi] ?
                             latched_addr[gi+ppfc_pkg::HIGH_BYTE_SHIFT] :
                             latched_addr[gi];
         ppfc_pin_slice u_a (
            .io_data    (io_data_a[gi]),
            .array_data (array_data_a[gi]),
            .array_oe   (array_oe_a[gi]),
            .array_owns (array_owns_a[gi]),
            .dir_bit    (state_reg.a_dir[gi]),
            .addr_sel   (state_reg.a_sel[gi]),
            .addr_bit   (latched_addr[gi]),
            .rep_active (rep_active),
            .rep_out    (rep_out),
            .rep_data   (cpu_wdata[gi]),
            .open_drain (state_reg.a_drv[gi] & ppfc_pkg::DRAIN_FIELD_AB[gi]),
            .pin_data   (a_pin_d[gi]),
            .pin_oe     (a_pin_e[gi])
         );
         ppfc_pin_slice u_b (
            .io_data    (io_data_b[gi]),
            .array_data (array_data_b[gi]),
            .array_oe   (array_oe_b[gi]),
            .array_owns (array_owns_b[gi]),
            .dir_bit    (state_reg.b_dir[gi]),
            .addr_sel   (state_reg.b_sel[gi]),
            .addr_bit   (b_addr[gi]),
            .rep_active (1'b0),
            .rep_out    (1'b0),
            .rep_data   (1'b0),
            .open_drain (state_reg.b_drv[gi] & ppfc_pkg::DRAIN_FIELD_AB[gi]),
            .pin_data   (b_pin_d[gi]),
            .pin_oe     (b_pin_e[gi])
         );
         ppfc_pin_slice u_c (
            .io_data    (io_data_c[gi]),
            .array_data (array_data_c[gi]),
            .array_oe   (array_oe_c[gi] & ppfc_pkg::C_USABLE_MASK[gi]),
            .array_owns (array_owns_c[gi]),
            .dir_bit    (state_reg.c_dir[gi] & ppfc_pkg::C_USABLE_MASK[gi]),
            .addr_sel   (1'b0),
            .addr_bit   (1'b0),
            .rep_active (1'b0),
            .rep_out    (1'b0),
            .rep_data   (1'b0),
            .open_drain (state_reg.c_drv[gi] & ppfc_pkg::C_USABLE_MASK[gi]),
            .pin_data   (c_pin_d[gi]),
            .pin_oe     (c_pin_e[gi])
         );
      end
   endgenerate

   // *******************************************
   // register file and pin staging
   // *******************************************
   always_comb begin
      state_next = state_reg;
      // register writes, any time
      if (reg_write) begin
         case (reg_addr)
            ppfc_pkg::OFS_A_ADDR_SEL: state_next.a_sel = reg_wdata;
            ppfc_pkg::OFS_B_ADDR_SEL: state_next.b_sel = reg_wdata;
            ppfc_pkg::OFS_A_DIR:      state_next.a_dir = reg_wdata;
            ppfc_pkg::OFS_B_DIR:      state_next.b_dir = reg_wdata;
            ppfc_pkg::OFS_C_DIR:      state_next.c_dir = reg_wdata & ppfc_pkg::C_USABLE_MASK;
            ppfc_pkg::OFS_A_DRIVE:    state_next.a_drv = reg_wdata;
            ppfc_pkg::OFS_B_DRIVE:    state_next.b_drv = reg_wdata;
            ppfc_pkg::OFS_C_DRIVE:    state_next.c_drv = reg_wdata & ppfc_pkg::C_USABLE_MASK;
            ppfc_pkg::OFS_MAP_CTRL:   state_next.map_ctrl = reg_wdata;
            default: ;
         endcase
      end
      // register reads, status reflects final enables
      state_next.rdata = ppfc_pkg::RESET_VALUE;
      if (reg_read) begin
         case (reg_addr)
            ppfc_pkg::OFS_A_ADDR_SEL:  state_next.rdata = state_reg.a_sel;
            ppfc_pkg::OFS_B_ADDR_SEL:  state_next.rdata = state_reg.b_sel;
            ppfc_pkg::OFS_A_DIR:       state_next.rdata = state_reg.a_dir;
            ppfc_pkg::OFS_B_DIR:       state_next.rdata = state_reg.b_dir;
            ppfc_pkg::OFS_C_DIR:       state_next.rdata = state_reg.c_dir;
            ppfc_pkg::OFS_A_DRIVE:     state_next.rdata = state_reg.a_drv;
            ppfc_pkg::OFS_B_DRIVE:     state_next.rdata = state_reg.b_drv;
            ppfc_pkg::OFS_C_DRIVE:     state_next.rdata = state_reg.c_drv;
            ppfc_pkg::OFS_MAP_CTRL:    state_next.rdata = state_reg.map_ctrl;
            ppfc_pkg::OFS_A_OE_STATUS: state_next.rdata = state_reg.a_oe;
            ppfc_pkg::OFS_B_OE_STATUS: state_next.rdata = state_reg.b_oe;
            ppfc_pkg::OFS_C_OE_STATUS: state_next.rdata = state_reg.c_oe;
            default:                   state_next.rdata = ppfc_pkg::RESET_VALUE;
         endcase
      end
      // pin staging
      state_next.a_out = a_pin_d;
      state_next.a_oe  = a_pin_e;
      state_next.b_out = b_pin_d;
      state_next.b_oe  = b_pin_e;
      state_next.c_out = c_pin_d;
      state_next.c_oe  = c_pin_e;
      state_next.slew  = (state_reg.a_drv | state_reg.b_drv) & ppfc_pkg::SLEW_FIELD_AB;
      // inbound repeater path, three-stage pin sampling
      state_next.pin_s1 = port_a_in;
      state_next.pin_s2 = state_reg.pin_s1;
      state_next.pin_s3 = state_reg.pin_s2;
      state_next.cpu_valid = rep_active & window & cpu_rd &
                             (state_reg.pin_s2 == state_reg.pin_s3);
      if (state_next.cpu_valid) begin
         state_next.cpu_rdata = state_reg.pin_s3;
      end
   end

   always_ff @(posedge clock or negedge reset_n) begin
      if (!reset_n) begin
         state_reg <= '0;
      end else begin
         state_reg <= state_next;
      end
   end

   assign reg_rdata       = state_reg.rdata;
   assign port_a_out      = state_reg.a_out;
   assign port_a_oe       = state_reg.a_oe;
   assign port_b_out      = state_reg.b_out;
   assign port_b_oe       = state_reg.b_oe;
   assign port_c_out      = state_reg.c_out;
   assign port_c_oe       = state_reg.c_oe;
   assign port_slew_fast  = state_reg.slew;
   assign cpu_rdata       = state_reg.cpu_rdata;
   assign cpu_rdata_valid = state_reg.cpu_valid;

   // *******************************************
   // checks
   // *******************************************
   property p_sel_reset;
      @(posedge clock) $rose(reset_n) |-> (state_reg.a_sel == 8'h00 && state_reg.b_drv == 8'h00);
   endproperty
   a_sel_reset: assert property (p_sel_reset) else $error("select not zero after reset");

   property p_rep_write_drive;
      @(posedge clock) disable iff (!reset_n)
      (rep_active && window && cpu_wr) |=> (port_a_oe == 8'hFF || state_reg.a_drv[7:4] != 4'h0);
   endproperty
   a_rep_write_drive: assert property (p_rep_write_drive) else $error("repeater not driving");

   property p_rep_read_off;
      @(posedge clock) disable iff (!reset_n)
      (rep_active && !cpu_wr) |=> (port_a_oe == 8'h00);
   endproperty
   a_rep_read_off: assert property (p_rep_read_off) else $error("repeater drives on read");

   property p_window_or;
      @(posedge clock) disable iff (!reset_n)
      (rep_active && cpu_wr && peripheral_window_select_one && state_reg.a_drv == 8'h00)
         |=> (port_a_oe == 8'hFF);
   endproperty
   a_window_or: assert property (p_window_or) else $error("select one ignored");

   property p_repeater_gate;
      @(posedge clock) disable iff (!reset_n)
      (!rep_active) |=> !cpu_rdata_valid;
   endproperty
   a_repeater_gate: assert property (p_repeater_gate) else $error("repeat without enable");

   property p_test_pins;
      @(posedge clock) disable iff (!reset_n)
      ##1 (port_c_oe & ~ppfc_pkg::C_USABLE_MASK) == 8'h00;
   endproperty
   a_test_pins: assert property (p_test_pins) else $error("test pin driven");

   property p_status_read;
      @(posedge clock) disable iff (!reset_n)
      (reg_read && reg_addr == ppfc_pkg::OFS_A_OE_STATUS) |=> (reg_rdata == $past(port_a_oe));
   endproperty
   a_status_read: assert property (p_status_read) else $error("status mismatch");

   property p_addr_drive;
      @(posedge clock) disable iff (!reset_n)
      (!rep_active && state_reg.a_sel[0] && state_reg.a_drv[3:0] == 4'h0)
         |=> (port_a_oe[0] && port_a_out[0] == $past(latched_addr[0]));
   endproperty
   a_addr_drive: assert property (p_addr_drive) else $error("address bit not driven");

   property p_slew;
      @(posedge clock) disable iff (!reset_n)
      (state_reg.b_drv[0]) |=> port_slew_fast[0];
   endproperty
   a_slew: assert property (p_slew) else $error("slew not selected");
endmodule
`default_nettype wire

// ==== ppfc_periph_model.sv ====
// Purpose: external parallel peripheral hung on the port A pins
// Assumes: the pins carry a weak pull-up when nobody drives them
// Notes:   drives its read byte only while selected and the port is released
`timescale 1ns/1ns
`default_nettype none
module ppfc_periph_model (
   input  wire logic       clock,
   input  wire logic       selected,
   input  wire logic       wr_strobe,
   input  wire logic [7:0] read_byte,
   input  wire logic [7:0] pin_out,
   input  wire logic [7:0] pin_oe,
   output var  logic [7:0] pin_in,
   output var  logic [7:0] written
);
   // ************************************************
   // pin resolution and capture
   // ************************************************
   // device bit wins, else peripheral when selected, else pull-up
   always_comb begin
      for (int i = 0; i < 8; i++) begin
         pin_in[i] = pin_oe[i] ? pin_out[i] : (selected ? read_byte[i] : 1'b1);
      end
   end
   // latch the outbound byte during a write in the window
   always_ff @(posedge clock) begin
      if (selected && wr_strobe) begin
         written <= pin_in;
      end
   end
endmodule
`default_nettype wire

// ==== tb.sv ====
// Purpose: self-checking bench for the port pin function control block
// Assumes: inputs change on the falling clock edge
// Notes:   register offsets come from the package
`timescale 1ns/1ns
`default_nettype none
module tb;
   // ************************************************
   // stimulus, wiring and instances
   // ************************************************
   logic        clock = 1'b0;
   logic        reset_n = 1'b0;
   logic [7:0]  reg_addr = 8'h00, reg_wdata = 8'h00, cpu_wdata = 8'h00, b_cfg = 8'h00;
   logic        reg_write = 1'b0, reg_read = 1'b0, ale = 1'b0, cpu_rd = 1'b0, cpu_wr = 1'b0;
   logic [15:0] cpu_addr = 16'h0000;
   logic        sel0 = 1'b0, sel1 = 1'b0, program_store_strobe = 1'b1;
   logic [7:0]  aoe = 8'h00, io_c = 8'h00, adata = 8'h00, p_byte = 8'h00, owns = 8'h00;
   wire  logic [7:0] reg_rdata, cpu_rdata, a_in, a_out, a_oe, b_out, b_oe, c_out, c_oe;
   wire  logic [7:0] slew, written;
   wire  logic       cpu_rdata_valid;
   int n_errors = 0;
   int check_count = 0;
   // window select qualified by the program strobe
   wire  logic       win0 = sel0 & program_store_strobe;
   wire  logic       win1 = sel1 & program_store_strobe;
   // free-running clock
   always #5 clock = ~clock;
   ppfc_top DUT (.clock(clock), .reset_n(reset_n), .reg_addr(reg_addr), .reg_write(reg_write),
      .reg_read(reg_read), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
      .address_latch_strobe(ale), .cpu_addr(cpu_addr), .cpu_wdata(cpu_wdata),
      .cpu_rd(cpu_rd), .cpu_wr(cpu_wr), .cpu_rdata(cpu_rdata), .cpu_rdata_valid(cpu_rdata_valid),
      .peripheral_window_select_zero(win0), .peripheral_window_select_one(win1),
      .port_b_high_byte_cfg(b_cfg), .array_oe_a(aoe), .array_oe_b(aoe), .array_oe_c(aoe),
      .array_owns_a(owns), .array_owns_b(owns), .array_owns_c(owns),
      .array_data_a(adata), .array_data_b(adata), .array_data_c(adata),
      .io_data_a(io_c), .io_data_b(io_c), .io_data_c(io_c), .port_a_in(a_in),
      .port_a_out(a_out), .port_a_oe(a_oe), .port_b_out(b_out), .port_b_oe(b_oe),
      .port_c_out(c_out), .port_c_oe(c_oe), .port_slew_fast(slew));
   ppfc_periph_model periph (.clock(clock), .selected(win0 | win1), .wr_strobe(cpu_wr),
      .read_byte(p_byte), .pin_out(a_out), .pin_oe(a_oe), .pin_in(a_in), .written(written));
   // ************************************************
   // shared tasks
   // ************************************************
   task automatic chk(input logic [7:0] got, input logic [7:0] exp);
      check_count++;
      if (got !== exp) begin
         n_errors++;
         $display("FAIL t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(negedge clock);
      reg_addr = a;
      reg_wdata = d;
      reg_write = 1'b1;
      @(negedge clock);
      reg_write = 1'b0;
   endtask
   task automatic rd(input logic [7:0] a, input logic [7:0] exp);
      @(negedge clock);
      reg_addr = a;
      reg_read = 1'b1;
      @(negedge clock);
      reg_read = 1'b0;
      chk(reg_rdata, exp);
   endtask
   task automatic settle;
      repeat (2) @(negedge clock);
   endtask
   task automatic latch(input logic [15:0] a);
      @(negedge clock);
      cpu_addr = a;
      ale = 1'b1;
      @(negedge clock);
      ale = 1'b0;
      @(negedge clock);
   endtask
   task automatic end_sim;
      $display("checks %0d errors %0d", check_count, n_errors);
      if (n_errors == 0 && check_count > 0) begin
         $display("Regression OK");
      end else begin
         $display("Regression broken");
      end
      $finish;
   endtask
   // ************************************************
   // scenarios
   // ************************************************
   task automatic t_reset;
      rd(ppfc_pkg::OFS_A_ADDR_SEL, 8'h00);
      rd(ppfc_pkg::OFS_B_ADDR_SEL, 8'h00);
      rd(ppfc_pkg::OFS_B_DRIVE, 8'h00);
      rd(ppfc_pkg::OFS_C_DRIVE, 8'h00);
      rd(ppfc_pkg::OFS_A_OE_STATUS, 8'h00);
      chk(a_oe, 8'h00);
   endtask
   task automatic t_addr;
      wr(ppfc_pkg::OFS_A_ADDR_SEL, 8'h81);
      latch(16'h12A5);
      cpu_addr = 16'h0000;
      settle();
      chk(a_oe, 8'h81);
      chk(a_out & 8'h81, 8'h81);
      rd(ppfc_pkg::OFS_A_OE_STATUS, 8'h81);
      wr(ppfc_pkg::OFS_A_ADDR_SEL, 8'h00);
      b_cfg = 8'hF0;
      wr(ppfc_pkg::OFS_B_ADDR_SEL, 8'hFF);
      latch(16'h3C5A);
      settle();
      chk(b_oe, 8'hFF);
      chk(b_out, 8'h3A);
      cpu_addr = 16'hC3E1;
      settle();
      chk(b_out, 8'hCA);
      wr(ppfc_pkg::OFS_B_ADDR_SEL, 8'h00);
      wr(ppfc_pkg::OFS_A_DIR, 8'h3C);
      settle();
      chk(a_oe, 8'h3C);
      rd(ppfc_pkg::OFS_A_DIR, 8'h3C);
      wr(ppfc_pkg::OFS_A_DIR, 8'h00);
   endtask
   task automatic t_drive;
      wr(ppfc_pkg::OFS_A_DRIVE, 8'hF0);
      wr(ppfc_pkg::OFS_B_DRIVE, 8'h0F);
      wr(ppfc_pkg::OFS_C_DRIVE, 8'hFF);
      rd(ppfc_pkg::OFS_C_DRIVE, 8'h9C);
      rd(ppfc_pkg::OFS_A_DRIVE, 8'hF0);
      settle();
      chk(slew, 8'h0F);
      wr(ppfc_pkg::OFS_C_DIR, 8'hFF);
      io_c = 8'h84;
      settle();
      chk(c_oe, 8'h18);
      chk(c_out, 8'h00);
      rd(ppfc_pkg::OFS_C_OE_STATUS, 8'h18);
      wr(ppfc_pkg::OFS_C_DRIVE, 8'h00);
      settle();
      chk(c_oe, 8'h9C);
      chk(c_out, 8'h84);
      rd(ppfc_pkg::OFS_C_DIR, 8'h9C);
      aoe = 8'h0F;
      owns = 8'h0F;
      adata = 8'h05;
      wr(ppfc_pkg::OFS_B_DIR, 8'h30);
      settle();
      chk(b_oe, 8'h3F);
      chk(b_out, 8'h85);
      rd(ppfc_pkg::OFS_B_OE_STATUS, 8'h3F);
      aoe = 8'h00;
      owns = 8'h00;
      adata = 8'h00;
      wr(ppfc_pkg::OFS_B_DIR, 8'h00);
      wr(ppfc_pkg::OFS_C_DIR, 8'h00);
      wr(ppfc_pkg::OFS_A_DRIVE, 8'h00);
   endtask
   task automatic t_repeater;
      int i;
      cpu_wdata = 8'h5C;
      cpu_wr = 1'b1;
      sel0 = 1'b1;
      settle();
      chk(a_oe, 8'h00);
      sel0 = 1'b0;
      wr(ppfc_pkg::OFS_MAP_CTRL, 8'h80);
      rd(ppfc_pkg::OFS_MAP_CTRL, 8'h80);
      settle();
      chk(a_oe, 8'h00);
      sel0 = 1'b1;
      settle();
      chk(a_oe, 8'hFF);
      chk(written, 8'h5C);
      sel0 = 1'b0;
      sel1 = 1'b1;
      cpu_wdata = 8'hA3;
      settle();
      chk(written, 8'hA3);
      cpu_wr = 1'b0;
      p_byte = 8'hC6;
      repeat (2) settle();
      chk(a_oe, 8'h00);
      cpu_rd = 1'b1;
      for (i = 0; i < 8 && cpu_rdata_valid !== 1'b1; i++) @(negedge clock);
      chk({7'h00, cpu_rdata_valid}, 8'h01);
      chk(cpu_rdata, 8'hC6);
      cpu_rd = 1'b0;
      sel1 = 1'b0;
      wr(ppfc_pkg::OFS_MAP_CTRL, 8'h00);
   endtask
   // main sequence after the reset hold
   initial begin
      repeat (16) @(negedge clock);
      reset_n = 1'b1;
      t_reset();
      t_addr();
      t_drive();
      t_repeater();
      end_sim();
   end
   // cut a hang short
   initial begin
      #200000;
      n_errors++;
      end_sim();
   end
endmodule
`default_nettype wire
